// ===== rtl/fcs_map.svh
// Offsets, field positions, command codes and timing constants of the flash host controller
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
`define FCS_AW            19
`define FCS_DW            16
// Host register byte offsets
`define FCS_OFF_CTRL      8'h00
`define FCS_OFF_ADDR      8'h04
`define FCS_OFF_WDATA     8'h08
`define FCS_OFF_STAT      8'h0C
`define FCS_OFF_RDATA     8'h10
`define FCS_OFF_PINS      8'h14
// Control word and pin register fields
`define FCS_CTRL_OP_LSB   0
`define FCS_CTRL_OP_MSB   2
`define FCS_CTRL_DEFER    3
`define FCS_CTRL_USE_PIN  4
`define FCS_PINS_PD       0
`define FCS_PINS_WP       1
// Device status word bits
`define FCS_SR_READY      7
`define FCS_SR_ERA_SUSP   6
`define FCS_SR_ERA_ERR    5
`define FCS_SR_WR_ERR     4
`define FCS_SR_SUPPLY     3
`define FCS_SR_WR_SUSP    2
`define FCS_SR_PROTECT    1
// Device command codes
`define FCS_CMD_ERASE     8'h20
`define FCS_CMD_CONFIRM   8'hD0
`define FCS_CMD_WRITE     8'h40
`define FCS_CMD_LOCK      8'h60
`define FCS_CMD_LOCK_BLK  8'h01
`define FCS_CMD_LOCK_PERM 8'hF1
`define FCS_CMD_READ_ARR  8'hFF
`define FCS_CMD_CLR_STAT  8'h50
// AXI responses
`define FCS_RESP_OKAY     2'h0
`define FCS_RESP_SLVERR   2'h2
`define FCS_RESP_DECERR   2'h3
// Bus timing in ns and derived cycle counts, least times rounded up
`define FCS_CLK_NS        20
`define FCS_T_WE_NS       60
`define FCS_T_RD_NS       120
`define FCS_T_RB_NS       200
`define FCS_CYC(t)        (((t) + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_WE_CYC        4'(`FCS_CYC(`FCS_T_WE_NS))
`define FCS_RD_CYC        4'(`FCS_CYC(`FCS_T_RD_NS) + 2)
`define FCS_RB_CYC        4'(`FCS_CYC(`FCS_T_RB_NS))
`endif

// ===== rtl/fcs_pkg.sv
// Types shared by the flash host controller modules
package fcs_pkg;
  typedef enum logic [2:0] {
    OP_ERASE, OP_WRITE, OP_LOCK_BLK, OP_LOCK_PERM,
    OP_UNLOCK, OP_CLR_STAT, OP_READ_ARR, OP_RSVD
  } fcs_op_e;
  typedef enum logic [2:0] {
    ERR_NONE, ERR_SUPPLY, ERR_PROTECT, ERR_SEQ, ERR_OP
  } fcs_err_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_W1, ST_W2, ST_WAIT, ST_POLL, ST_RDARR
  } fcs_state_e;
  typedef enum logic [2:0] {
    PC_IDLE, PC_SETUP, PC_PULSE, PC_HOLD, PC_READ
  } fcs_pc_e;
endpackage

// ===== rtl/fcs_bus_if.sv
// Request and answer carrier between the sequencer and the pin cycle engine
`timescale 1ns/10ps
`include "fcs_map.svh"
interface fcs_bus_if;
  logic                req;
  logic                wr;
  logic [`FCS_AW-1:0]  addr;
  logic [`FCS_DW-1:0]  wdata;
  logic                done;
  logic [`FCS_DW-1:0]  rdata;
  modport master (output req, wr, addr, wdata, input done, rdata);
  modport cycle  (input req, wr, addr, wdata, output done, rdata);
endinterface

// ===== rtl/fcs_pin_cycle.sv
// Single write or read cycle on the asynchronous flash pins
`timescale 1ns/10ps
`include "fcs_map.svh"
module fcs_pin_cycle
  import fcs_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  fcs_bus_if.cycle                bus,
  output logic [`FCS_AW-1:0]      flash_addr,
  output logic [`FCS_DW-1:0]      flash_dq_o,
  output logic                    flash_dq_oe,
  output logic                    flash_ce_n,
  output logic                    flash_oe_n,
  output logic                    flash_we_n,
  input  wire logic [`FCS_DW-1:0] flash_dq_i
);
  fcs_pc_e            st_ff;
  logic [3:0]         cnt_ff;
  logic               done_ff, dq_stable;
  logic [`FCS_DW-1:0] rdata_ff, dq_s1_ff, dq_s2_ff, dq_s3_ff;

  assign bus.done  = done_ff;
  assign bus.rdata = rdata_ff;
  // Data only counts once the last two stages agree
  assign dq_stable = (dq_s2_ff == dq_s3_ff);

  // Three-stage capture of the data pins
  always_ff @(posedge clk) begin
    dq_s1_ff <= flash_dq_i;
    dq_s2_ff <= dq_s1_ff;
    dq_s3_ff <= dq_s2_ff;
  end

  // Cycle engine; done blocks re-acceptance of the request just answered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff       <= PC_IDLE;
      cnt_ff      <= 4'h0;
      done_ff     <= 1'b0;
      rdata_ff    <= 16'h0000;
      flash_addr  <= 19'h00000;
      flash_dq_o  <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_we_n  <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      unique case (st_ff)
        PC_IDLE: if (bus.req && !done_ff) begin
          flash_addr <= bus.addr;
          flash_dq_o <= bus.wdata;
          flash_ce_n <= 1'b0;
          if (bus.wr) begin
            flash_dq_oe <= 1'b1;
            st_ff       <= PC_SETUP;
          end else begin
            flash_oe_n <= 1'b0;
            cnt_ff     <= `FCS_RD_CYC;
            st_ff      <= PC_READ;
          end
        end
        PC_SETUP: begin
          flash_we_n <= 1'b0;
          cnt_ff     <= `FCS_WE_CYC - 4'h1;
          st_ff      <= PC_PULSE;
        end
        PC_PULSE: if (cnt_ff == 4'h0) begin
          flash_we_n <= 1'b1;
          st_ff      <= PC_HOLD;
        end else begin
          cnt_ff <= cnt_ff - 4'h1;
        end
        PC_HOLD: begin
          flash_ce_n  <= 1'b1;
          flash_dq_oe <= 1'b0;
          done_ff     <= 1'b1;
          st_ff       <= PC_IDLE;
        end
        PC_READ: if (cnt_ff != 4'h0) begin
          cnt_ff <= cnt_ff - 4'h1;
        end else if (dq_stable) begin
          rdata_ff   <= dq_s3_ff;
          flash_ce_n <= 1'b1;
          flash_oe_n <= 1'b1;
          done_ff    <= 1'b1;
          st_ff      <= PC_IDLE;
        end
      endcase
    end
  end
endmodule // fcs_pin_cycle

// ===== rtl/fcs_ctrl.sv
// Flash host controller: AXI4-Lite registers, command sequencing, status checks
`timescale 1ns/10ps
`include "fcs_map.svh"
// Overview of operation
// [R01] Status bit 7 ready, 0 busy
// [R02] Status bit 6 erase suspended
// [R03] Status bit 5 erase or unlock failure
// [R04] Status bit 4 write or lock failure
// [R05] Status bit 3 program supply too low
// [R06] Status bit 2 word write suspended
// [R07] Status bit 1 protection abort
// [R08] Host masks reserved status bit 0
// [R09] Ignore bits 6..0 until ready
// [R10] Bits 5 and 4 both: bad sequence
// [R11] Supply bit updated only by operations
// [R12] Protect bit evaluated only after operations
// [R13] Erase: 20H then D0H at block
// [R14] Write: 40H then data, same address
// [R15] Lock: 60H then 01H or F1H
// [R16] Unlock all: 60H then D0H
// [R17] Write FFH to return to array
// [R18] Error bits sticky until clear status
// [R19] Error check may follow a series
// [R20] Check supply, protect, sequence, own bit
// [R21] Completion via ready pin or bit 7
// [R22] Ready pin low while algorithm runs
// [R23] Power-down clears the status word
// [R24] Array read mode after power-down exit
// [R25] Bad lock sequence sets bits 4, 5
// [R26] Reserved bit 0 reads zero
module fcs_ctrl
  import fcs_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic [`FCS_AW-1:0]      flash_addr,
  output logic [`FCS_DW-1:0]      flash_dq_o,
  output logic                    flash_dq_oe,
  input  wire logic [`FCS_DW-1:0] flash_dq_i,
  output logic                    flash_ce_n,
  output logic                    flash_oe_n,
  output logic                    flash_we_n,
  output logic                    flash_wp_n,
  output logic                    powerdown_reset_in_n,
  input  wire logic               ready_busy_out
);
  fcs_bus_if bus ();
  // Sequencer state
  fcs_state_e         state_ff, nxt_state;
  fcs_op_e            op_ff;
  fcs_err_e           err_ff, nxt_err;
  logic               defer_ff, use_pin_ff, done_ff, pd_ff, wp_ff;
  logic [`FCS_AW-1:0] addr_ff;
  logic [`FCS_DW-1:0] wdat_ff, rdarr_ff;
  logic [7:0]         sr_ff;
  logic [3:0]         settle_ff;
  // Ready pin synchroniser
  logic               rb_s1_ff, rb_s2_ff, rb_s3_ff, rb_lvl_ff;
  // AXI slave state
  logic               aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [7:0]         awaddr_ff;
  logic [31:0]        wdata_ff, rdata_ff;
  logic [3:0]         wstrb_ff;
  logic [1:0]         bresp_ff, rresp_ff;
  // Decoded wires
  logic               wr_go, w_ctrl, w_addr, w_wdat, w_pins, w_mapped, busy, start_ok;
  logic               start, finish, own_err, sr_ready, rd_mapped;
  logic [31:0]        wmask, addr_new, wdat_new, stat_word, rd_word;
  fcs_op_e            req_op;
  logic [7:0]         cmd1, sr_m;
  logic [15:0]        cmd2;

  fcs_pin_cycle u_pc (
    .clk         (clk),
    .rst_n       (rst_n),
    .bus         (bus.cycle),
    .flash_addr  (flash_addr),
    .flash_dq_o  (flash_dq_o),
    .flash_dq_oe (flash_dq_oe),
    .flash_ce_n  (flash_ce_n),
    .flash_oe_n  (flash_oe_n),
    .flash_we_n  (flash_we_n),
    .flash_dq_i  (flash_dq_i)
  );

  // AXI handshakes; one write and one read in flight at most
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Write decode; acts once address and data are both held
  assign wr_go    = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign w_ctrl   = (awaddr_ff == `FCS_OFF_CTRL);
  assign w_addr   = (awaddr_ff == `FCS_OFF_ADDR);
  assign w_wdat   = (awaddr_ff == `FCS_OFF_WDATA);
  assign w_pins   = (awaddr_ff == `FCS_OFF_PINS);
  assign w_mapped = w_ctrl || w_addr || w_wdat || w_pins
                    || (awaddr_ff == `FCS_OFF_STAT) || (awaddr_ff == `FCS_OFF_RDATA);
  assign wmask    = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign addr_new = ({13'h0000, addr_ff} & ~wmask) | (wdata_ff & wmask);
  assign wdat_new = ({16'h0000, wdat_ff} & ~wmask) | (wdata_ff & wmask);

  // Start only when idle and powered; refusals answer SLVERR
  assign req_op   = fcs_op_e'(wdata_ff[`FCS_CTRL_OP_MSB:`FCS_CTRL_OP_LSB]);
  assign busy     = (state_ff != ST_IDLE);
  assign start_ok = !busy && !pd_ff && wstrb_ff[0] && (req_op != OP_RSVD);
  assign start    = wr_go && w_ctrl && start_ok;
  assign finish   = busy && (nxt_state == ST_IDLE);

  // First command word of each sequence
  assign cmd1 = (op_ff == OP_ERASE)    ? `FCS_CMD_ERASE :     // [R13]
                (op_ff == OP_WRITE)    ? `FCS_CMD_WRITE :     // [R14]
                (op_ff == OP_CLR_STAT) ? `FCS_CMD_CLR_STAT :
                (op_ff == OP_READ_ARR) ? `FCS_CMD_READ_ARR :  // [R17]
                `FCS_CMD_LOCK;                                // [R15] [R16]
  // Second word: confirm code, or the data itself for a word write
  assign cmd2 = (op_ff == OP_WRITE)     ? wdat_ff :                    // [R14]
                (op_ff == OP_LOCK_BLK)  ? {8'h00, `FCS_CMD_LOCK_BLK} :  // [R15]
                (op_ff == OP_LOCK_PERM) ? {8'h00, `FCS_CMD_LOCK_PERM} : // [R15]
                {8'h00, `FCS_CMD_CONFIRM};                             // [R13] [R16]

  // Requests to the pin engine; both words of a pair go to the same address
  assign bus.req   = (state_ff == ST_W1) || (state_ff == ST_W2)
                     || (state_ff == ST_POLL) || (state_ff == ST_RDARR);
  assign bus.wr    = (state_ff == ST_W1) || (state_ff == ST_W2);
  assign bus.addr  = addr_ff;                                    // [R13] [R14]
  assign bus.wdata = (state_ff == ST_W2) ? cmd2 : {8'h00, cmd1};

  // Status word as read from the device, reserved bit dropped
  assign sr_m     = {bus.rdata[7:1], 1'b0};                      // [R08] [R26]
  assign sr_ready = sr_m[`FCS_SR_READY];                         // [R01]
  assign own_err  = ((op_ff == OP_ERASE) || (op_ff == OP_UNLOCK))
                    ? sr_m[`FCS_SR_ERA_ERR]                      // [R03]
                    : sr_m[`FCS_SR_WR_ERR];                      // [R04]

  // Full check in fixed order; deferred checks leave sticky bits for later
  always_comb begin
    nxt_err = ERR_NONE;
    if (defer_ff) begin
      nxt_err = ERR_NONE;                                        // [R19]
    end else if (sr_m[`FCS_SR_SUPPLY]) begin
      nxt_err = ERR_SUPPLY;                                      // [R20] [R05]
    end else if (sr_m[`FCS_SR_PROTECT]) begin
      nxt_err = ERR_PROTECT;                                     // [R20] [R07]
    end else if (sr_m[`FCS_SR_ERA_ERR] && sr_m[`FCS_SR_WR_ERR]) begin
      nxt_err = ERR_SEQ;                                         // [R10] [R25]
    end else if (own_err) begin
      nxt_err = ERR_OP;                                          // [R20]
    end
  end

  // Sequencer; power-down aborts whatever runs
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (start) begin
        nxt_state = ST_W1;
      end
      ST_W1: if (bus.done) begin
        nxt_state = (op_ff == OP_CLR_STAT) ? ST_IDLE :           // [R18]
                    (op_ff == OP_READ_ARR) ? ST_RDARR : ST_W2;
      end
      ST_W2: if (bus.done) begin
        nxt_state = use_pin_ff ? ST_WAIT : ST_POLL;              // [R21]
      end
      ST_WAIT: if ((settle_ff == 4'h0) && rb_lvl_ff) begin
        nxt_state = ST_POLL;                                     // [R22]
      end
      // Bits below the ready bit mean nothing until it is set
      ST_POLL: if (bus.done && sr_ready) begin
        nxt_state = ST_IDLE;                                     // [R09]
      end
      ST_RDARR: if (bus.done) begin
        nxt_state = ST_IDLE;                                     // [R24]
      end
    endcase
    if (pd_ff) begin
      nxt_state = ST_IDLE;
    end
  end

  // Ready pin: three stages, level taken when the last two agree
  always_ff @(posedge clk) begin
    rb_s1_ff <= ready_busy_out;
    rb_s2_ff <= rb_s1_ff;
    rb_s3_ff <= rb_s2_ff;
    if (!rst_n) begin
      rb_lvl_ff <= 1'b1;
    end else if (rb_s2_ff == rb_s3_ff) begin
      rb_lvl_ff <= rb_s3_ff;                                     // [R21]
    end
  end

  // AXI write channel holding registers and response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `FCS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= !w_mapped ? `FCS_RESP_DECERR :
                      (w_ctrl && !start_ok) ? `FCS_RESP_SLVERR : `FCS_RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Register read mux; status word reports the sequencer and last device status
  assign stat_word = {16'h0000, sr_ff, 1'b0, err_ff, 1'b0, rb_lvl_ff, done_ff, busy};
  assign rd_mapped = s_axi_araddr inside {`FCS_OFF_CTRL, `FCS_OFF_ADDR, `FCS_OFF_WDATA,
                                          `FCS_OFF_STAT, `FCS_OFF_RDATA, `FCS_OFF_PINS};
  assign rd_word   = (s_axi_araddr == `FCS_OFF_CTRL)  ? {27'h0, use_pin_ff, defer_ff, op_ff} :
                     (s_axi_araddr == `FCS_OFF_ADDR)  ? {13'h0, addr_ff} :
                     (s_axi_araddr == `FCS_OFF_WDATA) ? {16'h0, wdat_ff} :
                     (s_axi_araddr == `FCS_OFF_STAT)  ? stat_word :
                     (s_axi_araddr == `FCS_OFF_RDATA) ? {16'h0, rdarr_ff} :
                     (s_axi_araddr == `FCS_OFF_PINS)  ? {30'h0, wp_ff, pd_ff} : 32'h00000000;

  // AXI read channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `FCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_mapped ? `FCS_RESP_OKAY : `FCS_RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Settings; operation fields frozen while busy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_ff      <= OP_READ_ARR;
      defer_ff   <= 1'b0;
      use_pin_ff <= 1'b0;
      addr_ff    <= 19'h00000;
      wdat_ff    <= 16'h0000;
      pd_ff      <= 1'b0;
      wp_ff      <= 1'b1;
    end else if (wr_go) begin
      if (start) begin
        op_ff      <= req_op;
        defer_ff   <= wdata_ff[`FCS_CTRL_DEFER];
        use_pin_ff <= wdata_ff[`FCS_CTRL_USE_PIN];
      end
      if (w_addr && !busy) begin
        addr_ff <= addr_new[`FCS_AW-1:0];
      end
      if (w_wdat && !busy) begin
        wdat_ff <= wdat_new[`FCS_DW-1:0];
      end
      if (w_pins && wstrb_ff[0]) begin
        pd_ff <= wdata_ff[`FCS_PINS_PD];
        wp_ff <= wdata_ff[`FCS_PINS_WP];
      end
    end
  end
  // Pin levels follow the settings register
  assign powerdown_reset_in_n = !pd_ff;
  assign flash_wp_n           = wp_ff;
  // Sequencer registers and captured results
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff  <= ST_IDLE;
      err_ff    <= ERR_NONE;
      sr_ff     <= 8'h00;
      rdarr_ff  <= 16'h0000;
      done_ff   <= 1'b0;
      settle_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      if (start) begin
        done_ff <= 1'b0;
      end else if (finish) begin
        done_ff <= 1'b1;
      end
      // Ready pin needs time to fall before its level means anything
      if ((state_ff == ST_W2) && bus.done) begin
        settle_ff <= `FCS_RB_CYC;
      end else if (settle_ff != 4'h0) begin
        settle_ff <= settle_ff - 4'h1;
      end
      if (pd_ff) begin
        sr_ff  <= 8'h00;                                         // [R23]
        err_ff <= ERR_NONE;
      end else if ((state_ff == ST_POLL) && finish) begin
        sr_ff  <= sr_m;                                          // [R02] [R06] [R11] [R12]
        err_ff <= nxt_err;
      end else if ((state_ff == ST_W1) && finish) begin
        sr_ff  <= 8'h00;                                         // [R18]
        err_ff <= ERR_NONE;
      end
      if ((state_ff == ST_RDARR) && bus.done) begin
        rdarr_ff <= bus.rdata;
      end
    end
  end
endmodule // fcs_ctrl

// ===== bench/fcs_flash_model.sv
// Behavioural flash device: command decode, status word and ready pin
`timescale 1ns/10ps
module fcs_flash_model (
  input  wire logic        clk,
  input  wire logic [15:0] flash_dq_o,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic        powerdown_reset_in_n,
  input  wire logic [2:0]  inj,
  input  wire logic        slow,
  output logic [15:0]      flash_dq_i,
  output logic             ready_busy_out
);
  logic [7:0]  sr_ff = 8'h00, bsy_ff = 8'h00, own, c;
  logic [2:0]  md_ff = 3'h0;
  logic [15:0] word_ff = 16'h0000, last_ff = 16'h0000, val;
  logic        we_q = 1'b1, take, good;
  // A command lands where the strobe rises inside a selected cycle
  assign take = flash_we_n && !we_q && !flash_ce_n;
  assign c = flash_dq_o[7:0];
  assign own = (md_ff == 3'h2 || (md_ff == 3'h4 && c == 8'hD0)) ? 8'h20 : 8'h10;
  assign good = md_ff == 3'h3 || (md_ff == 3'h2 ? c == 8'hD0 : c inside {8'h01, 8'hF1, 8'hD0});
  // Busy shows junk low bits; reserved bit 0 reads 1 so masking is exercised
  assign val = (md_ff == 3'h0) ? word_ff : {8'h00, (bsy_ff != 8'h00) ? 8'h55 : sr_ff | 8'h81};
  assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? val : ~last_ff;  // Released bus toggles
  assign ready_busy_out = (bsy_ff == 8'h00);
  // Command decode; error bits pile up until cleared
  always @(posedge clk) begin
    we_q <= flash_we_n;
    last_ff <= flash_dq_i;
    if (bsy_ff != 8'h00) bsy_ff <= bsy_ff - 8'h01;
    if (!powerdown_reset_in_n) begin
      sr_ff <= 8'h00;
      md_ff <= 3'h0;
      bsy_ff <= 8'h00;
    end else if (take && md_ff >= 3'h2) begin
      sr_ff <= sr_ff | (inj[0] ? 8'h08 | own : 8'h00) | (inj[1] ? 8'h02 | own : 8'h00)
               | ((inj[2] || !good) ? 8'h30 : 8'h00);
      if (md_ff == 3'h3) word_ff <= flash_dq_o;
      md_ff <= 3'h1;
      bsy_ff <= slow ? 8'd200 : 8'd2;
    end else if (take && c == 8'h50) sr_ff <= 8'h00;
    else if (take) md_ff <= (c == 8'h20) ? 3'h2 : (c == 8'h40) ? 3'h3 : (c == 8'h60) ? 3'h4
                            : (c == 8'hFF) ? 3'h0 : 3'h1;
  end
endmodule  // fcs_flash_model

// ===== bench/fcs_ctrl_asserts.sv
// Port-level checks of the flash host controller
`timescale 1ns/10ps
module fcs_ctrl_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        flash_we_n,
  input wire logic        flash_ce_n,
  input wire logic        flash_dq_oe,
  input wire logic [15:0] flash_dq_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Answers stand until taken; a pending response blocks new writes
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("rdata moved");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken in response");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Strobe shape: data set up first, pulse three cycles, data held after
  AST_WE_PULSE: assert property ($fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n)
    else $error("pulse width");
  AST_WE_SEL: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("strobe unselected");
  AST_SETUP: assert property ($rose(flash_dq_oe) |-> flash_we_n ##1 !flash_we_n)
    else $error("no data setup");
  AST_HOLD: assert property (!flash_we_n |=> $stable(flash_dq_o))
    else $error("data moved");
endmodule  // fcs_ctrl_asserts
bind fcs_ctrl fcs_ctrl_asserts u_chk (.*);

// ===== bench/testbench.sv
// Self-checking bench: AXI4-Lite driver, device model, random operations
`timescale 1ns/10ps
`include "fcs_map.svh"
module testbench;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, clk = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, acc = 8'h00, own;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [2:0]  inj = 3'h0, op;
  logic [1:0]  rsp, md, hs;
  logic [15:0] wd, wexp = 16'h0000;
  int          n_mismatch = 0, comparisons = 0, cyc = 0, seed = 76;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_wp_n;
  wire logic   powerdown_reset_in_n, ready_busy_out;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [18:0] flash_addr;
  wire logic [15:0] flash_dq_o, flash_dq_i;
  fcs_ctrl DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ce_n,
    .flash_oe_n, .flash_we_n, .flash_wp_n, .powerdown_reset_in_n, .ready_busy_out);
  fcs_flash_model u_dev (.clk, .flash_dq_o, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .powerdown_reset_in_n, .inj, .slow, .flash_dq_i, .ready_busy_out);
  // Clock and cycle ceiling
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready sampled mid-cycle, where it is settled
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      hs = {s_axi_awready, s_axi_wready};
      @(posedge clk);
      if (hs[1]) s_axi_awvalid <= 1'b0;
      if (hs[0]) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(negedge clk); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  // Start an op, poll for done
  task automatic run(input logic [2:0] o, input logic [1:0] m);
    axw(`FCS_OFF_CTRL, {27'h0, m, o}, `FCS_RESP_OKAY);
    do axr(`FCS_OFF_STAT); while (rd[1] !== 1'b1);
  endtask
  function automatic logic [2:0] cls(input logic [7:0] s, input logic own5);
    return s[3] ? 3'd1 : s[1] ? 3'd2 : (s[5] && s[4]) ? 3'd3 : (own5 ? s[5] : s[4]) ? 3'd4 : 3'd0;
  endfunction
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    axr(`FCS_OFF_STAT);
    chk(rd, 32'h4);
    axr(8'h18);
    chk({rd, rsp}, {32'h0, `FCS_RESP_DECERR});
    $display("Test reset values done");
    // Each op once, then random ops and faults
    for (int i = 0; i < 18; i++) begin
      op = (i < 7) ? 3'(i) : 3'({$random(seed)} % 7);
      md = 2'($random(seed));
      wd = 16'($random(seed));
      inj <= 3'($random(seed));
      slow <= 1'($random(seed));
      axw(`FCS_OFF_ADDR, {13'h0, 19'($random(seed))}, `FCS_RESP_OKAY);
      axw(`FCS_OFF_WDATA, {16'h0, wd}, `FCS_RESP_OKAY);
      run(op, md);
      own = (op == 3'h0 || op == 3'h4) ? 8'h20 : 8'h10;
      if (op == 3'h1) wexp = wd;
      if (op == 3'h5) acc = 8'h00;
      if (op < 3'h5) begin
        acc = acc | (inj[0] ? 8'h08 | own : 8'h00) | (inj[1] ? 8'h02 | own : 8'h00);
        acc = acc | (inj[2] ? 8'h30 : 8'h00);
        chk(rd[15:8], 8'h80 | acc);
        chk(rd[6:4], md[0] ? 3'd0 : cls(acc, own[5]));
      end
      if (op == 3'h6) axr(`FCS_OFF_RDATA);
      if (op == 3'h6) chk(rd, {16'h0, wexp});
    end
    $display("Test random operations done");
    slow <= 1'b1;
    axw(`FCS_OFF_CTRL, 32'h7, `FCS_RESP_SLVERR);
    axw(8'h18, 32'h0, `FCS_RESP_DECERR);
    axw(`FCS_OFF_CTRL, 32'h0, `FCS_RESP_OKAY);
    axw(`FCS_OFF_CTRL, 32'h0, `FCS_RESP_SLVERR);
    axw(`FCS_OFF_PINS, 32'h1, `FCS_RESP_OKAY);
    chk({powerdown_reset_in_n, flash_wp_n}, 2'b00);
    axw(`FCS_OFF_CTRL, 32'h0, `FCS_RESP_SLVERR);
    axr(`FCS_OFF_STAT);
    chk({rd[15:4], rd[0]}, 13'h0);
    axw(`FCS_OFF_PINS, 32'h2, `FCS_RESP_OKAY);
    chk({powerdown_reset_in_n, flash_wp_n}, 2'b11);
    run(3'h6, 2'b00);
    axr(`FCS_OFF_RDATA);
    chk(rd, {16'h0, wexp});
    $display("Test refusals and power-down done");
    summarize();
  end
endmodule  // testbench
